// ---- media_link_pin_port.sv ----
// Pin-level port of the media link, timed by the received link clock
module media_link_pin_port
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic linkClockIn,
	input wire logic linkSharedDataIn,
	input wire logic linkSharedSignalIn,
	input wire link_port_pkg::pin_mode_t pinMode,
	input wire logic txStart,
	input wire link_port_pkg::tx_byte_t txBytes,
	output logic txBusy,
	output link_port_pkg::pin_drive_t linkSharedData,
	output link_port_pkg::pin_drive_t linkSharedSignal,
	output link_port_pkg::pin_drive_t linkDataOut,
	output link_port_pkg::pin_drive_t linkSignalOut,
	output logic [7:0] rxData,
	output logic [7:0] rxSignal,
	output logic rxValid
);

	////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic clkSync;
	logic datSync;
	logic sigSync;

	sync_two_ff uClk (.mclk(mclk), .sys_rst(sys_rst), .async(linkClockIn), .synced(clkSync));
	sync_two_ff uDat (.mclk(mclk), .sys_rst(sys_rst), .async(linkSharedDataIn), .synced(datSync));
	sync_two_ff uSig (.mclk(mclk), .sys_rst(sys_rst), .async(linkSharedSignalIn), .synced(sigSync));

	////////////////////////////////////////////////////////////////
	// Link clock edge detection
	logic clkPrev;
	logic linkRise;
	logic linkFall;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			clkPrev <= 1'b0;
		else
			clkPrev <= clkSync;
	end

	assign linkRise = clkSync && !clkPrev;
	assign linkFall = !clkSync && clkPrev;

	////////////////////////////////////////////////////////////////
	// Transmit sequencer
	typedef enum logic [1:0]
	{
		TX_IDLE,
		TX_WAIT,
		TX_SHIFT
	} tx_state_t;

	tx_state_t txState;
	logic [2:0] txBit;
	link_port_pkg::tx_byte_t txShift;
	link_port_pkg::pin_mode_t txMode;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			txState <= TX_IDLE;
			txBit <= link_port_pkg::BIT_FIRST;
			txShift <= '0;
			txMode <= link_port_pkg::MODE_THREE_PIN;
		end
		else
		begin
			unique case (txState)
				TX_IDLE:
				begin
					if (txStart)
					begin
						txShift <= txBytes;
						txMode <= pinMode;
						txBit <= link_port_pkg::BIT_FIRST;
						txState <= TX_WAIT;
					end
				end
				TX_WAIT:
				begin
					if (linkFall)
						txState <= TX_SHIFT;
				end
				TX_SHIFT:
				begin
					if (linkFall)
					begin
						txShift <= {txShift.data << 1, txShift.signal << 1};
						if (txBit == link_port_pkg::BIT_LAST)
							txState <= TX_IDLE;
						else
							txBit <= txBit + 3'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			txBusy <= 1'b0;
		else
			txBusy <= (txState != TX_IDLE) || txStart;
	end

	////////////////////////////////////////////////////////////////
	// Pin drivers
	logic sending;
	logic fiveMode;

	assign sending = (txState == TX_SHIFT);
	assign fiveMode = (txMode == link_port_pkg::MODE_FIVE_PIN);

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			linkSharedData <= '0;
			linkSharedSignal <= '0;
			linkDataOut <= '0;
			linkSignalOut <= '0;
		end
		else
		begin
			// Shared pins only while sending in three-pin mode
			linkSharedData.oe <= sending && !fiveMode;
			linkSharedSignal.oe <= sending && !fiveMode;
			linkSharedData.out <= txShift.data[7];
			linkSharedSignal.out <= txShift.signal[7];
			// Dedicated pins only in five-pin mode
			linkDataOut.oe <= sending && fiveMode;
			linkSignalOut.oe <= sending && fiveMode;
			linkDataOut.out <= txShift.data[7];
			linkSignalOut.out <= txShift.signal[7];
		end
	end

	////////////////////////////////////////////////////////////////
	// Receive shifter, sampled on link clock rise
	logic [2:0] rxBit;
	logic [7:0] rxDatShift;
	logic [7:0] rxSigShift;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rxBit <= link_port_pkg::BIT_FIRST;
			rxDatShift <= link_port_pkg::BYTE_ZERO;
			rxSigShift <= link_port_pkg::BYTE_ZERO;
			rxData <= link_port_pkg::BYTE_ZERO;
			rxSignal <= link_port_pkg::BYTE_ZERO;
			rxValid <= 1'b0;
		end
		else
		begin
			rxValid <= 1'b0;
			if (linkRise && !sending)
			begin
				rxDatShift <= {rxDatShift[6:0], datSync};
				rxSigShift <= {rxSigShift[6:0], sigSync};
				rxBit <= rxBit + 3'h1;
				if (rxBit == link_port_pkg::BIT_LAST)
				begin
					rxData <= {rxDatShift[6:0], datSync};
					rxSignal <= {rxSigShift[6:0], sigSync};
					rxValid <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Assertions
	a_five_data_off: assert property (@(posedge mclk) disable iff (sys_rst)
		fiveMode |=> !linkSharedData.oe)
		else $error("shared data driven in five-pin mode");
	a_five_sig_off: assert property (@(posedge mclk) disable iff (sys_rst)
		fiveMode |=> !linkSharedSignal.oe)
		else $error("shared signal driven in five-pin mode");
	a_dout_three_off: assert property (@(posedge mclk) disable iff (sys_rst)
		!fiveMode |=> !linkDataOut.oe)
		else $error("data-out driven in three-pin mode");
	a_sout_three_off: assert property (@(posedge mclk) disable iff (sys_rst)
		!fiveMode |=> !linkSignalOut.oe)
		else $error("signal-out driven in three-pin mode");
	a_idle_no_drive: assert property (@(posedge mclk) disable iff (sys_rst)
		!sending |=> !(linkSharedData.oe || linkDataOut.oe))
		else $error("driver on while not sending");
	a_idle_sig_off: assert property (@(posedge mclk) disable iff (sys_rst)
		!sending |=> !(linkSharedSignal.oe || linkSignalOut.oe))
		else $error("signal driver on while not sending");
	a_reset_hiz: assert property (@(posedge mclk)
		sys_rst |=> !(linkSharedData.oe || linkSharedSignal.oe || linkDataOut.oe
		|| linkSignalOut.oe))
		else $error("driver on after reset");
	a_shift_on_fall: assert property (@(posedge mclk) disable iff (sys_rst)
		(sending && !linkFall) |=> $stable(txBit))
		else $error("transmit bit moved without link clock fall");
	a_rx_on_rise: assert property (@(posedge mclk) disable iff (sys_rst)
		!linkRise |=> $stable(rxBit))
		else $error("receive bit moved without link clock rise");

	c_tx_three: cover property (@(posedge mclk) sending && !fiveMode);
	c_tx_five: cover property (@(posedge mclk) sending && fiveMode);
	c_rx_byte: cover property (@(posedge mclk) rxValid);
	c_mid_reset: cover property (@(posedge mclk) sys_rst && linkSharedData.oe);

endmodule : media_link_pin_port

// ---- link_port_pkg.sv ----
// Package: link pin port types and constants
package link_port_pkg;

	// Link clock and mclk figures
	localparam int LINK_CLOCK_KHZ = 49152;
	localparam int FRAME_RATE_KHZ = 48;
	localparam int MCLK_KHZ = 100000;
	// Byte width of the serial streams
	localparam int BYTE_BITS = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef enum logic
	{
		MODE_THREE_PIN,
		MODE_FIVE_PIN
	} pin_mode_t;

	// One two-way or three-state pin at the design port
	typedef struct packed
	{
		logic out;
		logic oe;
	} pin_drive_t;

	// Bytes the device sends in one transfer
	typedef struct packed
	{
		logic [7:0] data;
		logic [7:0] signal;
	} tx_byte_t;

endpackage : link_port_pkg

// ---- sync_two_ff.sv ----
// Two-flop synchroniser for one input bit
module sync_two_ff
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic async,
	output logic synced
);

	logic firstStage;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			firstStage <= 1'b0;
			synced <= 1'b0;
		end
		else
		begin
			firstStage <= async;
			synced <= firstStage;
		end
	end

endmodule : sync_two_ff

// ---- link_controller_model.sv ----
// Far-end link controller model: link clock and line drivers
module link_controller_model
(
	input wire logic run,
	input wire logic load,
	input wire logic [7:0] dataByte,
	input wire logic [7:0] signalByte,
	input wire link_port_pkg::pin_drive_t devData,
	input wire link_port_pkg::pin_drive_t devSignal,
	output logic linkClock,
	output logic dataWire,
	output logic signalWire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] dataShift = 8'h00;
	logic [7:0] sigShift = 8'h00;
	initial linkClock = 1'b0;
	// Clock stands still outside frames
	always #40 if (run) linkClock = ~linkClock;
	always @(negedge linkClock or posedge load)
	begin
		dataShift <= load ? dataByte : {dataShift[6:0], ~dataShift[7]};
		sigShift <= load ? signalByte : {sigShift[6:0], ~sigShift[7]};
	end
	// Released while the device drives the shared pins (three-pin mode only)
	assign dataWire = devData.oe ? devData.out : dataShift[7];
	assign signalWire = devSignal.oe ? devSignal.out : sigShift[7];
endmodule : link_controller_model

// ---- media_link_pin_port_bench.sv ----
// Testbench of the media link pin port
module media_link_pin_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, sysRst = 1, run = 0, load = 0, txStart = 0, sawValid = 0;
	logic linkClock, dataWire, signalWire, txBusy, rxValid;
	logic [7:0] rxData, rxSignal, shD, shS, deD, deS;
	logic [7:0] ldD = 8'hC6, ldS = 8'h39;
	link_port_pkg::pin_mode_t pinMode = link_port_pkg::MODE_THREE_PIN;
	link_port_pkg::tx_byte_t txBytes = 16'h0000;
	link_port_pkg::pin_drive_t lsD, lsS, ldo, lso;
	int n_fail = 0, n_compared = 0, cSh, cDe;
	always #5 mclk = ~mclk;
	always @(posedge mclk) if (rxValid === 1'b1) sawValid <= 1'b1;
	media_link_pin_port media_link_pin_port_i (.mclk(mclk), .sys_rst(sysRst),
		.linkClockIn(linkClock), .linkSharedDataIn(dataWire),
		.linkSharedSignalIn(signalWire), .pinMode(pinMode), .txStart(txStart),
		.txBytes(txBytes), .txBusy(txBusy), .linkSharedData(lsD),
		.linkSharedSignal(lsS), .linkDataOut(ldo), .linkSignalOut(lso),
		.rxData(rxData), .rxSignal(rxSignal), .rxValid(rxValid));
	link_controller_model link_controller_model_i (.run(run), .load(load),
		.dataByte(ldD), .signalByte(ldS), .devData(lsD), .devSignal(lsS),
		.linkClock(linkClock), .dataWire(dataWire), .signalWire(signalWire));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask : chk
	task send(input link_port_pkg::pin_mode_t m, input logic [15:0] b);
		@(negedge mclk) pinMode = m;
		txBytes = b;
		txStart = 1'b1;
		@(negedge mclk) {txStart, run, cSh, cDe} = {1'b0, 1'b1, 64'd0};
		chk("busy high", 8'h01, {7'h00, txBusy});
		repeat (9) @(negedge linkClock)
		begin
			if (lsD.oe | lsS.oe) cSh++;
			if (ldo.oe | lso.oe) cDe++;
			{shD, shS} = {shD[6:0], lsD.out, shS[6:0], lsS.out};
			{deD, deS} = {deD[6:0], ldo.out, deS[6:0], lso.out};
		end
		@(negedge mclk) run = 0;
		repeat (5) @(negedge mclk);
		chk("busy", 8'h00, {7'h00, txBusy});
	endtask : send
	////////////////////////////////////////////////////////////////////////////////
	task test_reset;
		repeat (5) @(negedge mclk);
		chk("reset oe", 8'h00, {3'h0, lsD.oe, lsS.oe, ldo.oe, lso.oe, txBusy});
		@(negedge mclk) sysRst = 0;
		repeat (2) @(negedge mclk);
		chk("after oe", 8'h00, {3'h0, lsD.oe, lsS.oe, ldo.oe, lso.oe, txBusy});
		$display("test reset done");
	endtask : test_reset
	task test_receive;
		@(negedge mclk) load = 1;
		@(negedge mclk) {load, run} = 2'b01;
		repeat (8) @(negedge linkClock);
		@(negedge mclk) run = 0;
		repeat (8) @(negedge mclk);
		chk("rx valid", 8'h01, {7'h00, sawValid});
		chk("rx data", ldD, rxData);
		chk("rx signal", ldS, rxSignal);
		$display("test receive done");
	endtask : test_receive
	task test_three_pin;
		send(link_port_pkg::MODE_THREE_PIN, 16'hA53C);
		chk("shared count", 8'h08, 8'(cSh));
		chk("dedicated count", 8'h00, 8'(cDe));
		chk("shared data", 8'hA5, shD);
		chk("shared signal", 8'h3C, shS);
		$display("test three pin done");
	endtask : test_three_pin
	task test_five_pin;
		send(link_port_pkg::MODE_FIVE_PIN, 16'h5AC3);
		chk("shared count", 8'h00, 8'(cSh));
		chk("dedicated count", 8'h08, 8'(cDe));
		chk("data out", 8'h5A, deD);
		chk("signal out", 8'hC3, deS);
		$display("test five pin done");
	endtask : test_five_pin
	task test_mid_reset;
		@(negedge mclk) pinMode = link_port_pkg::MODE_THREE_PIN;
		txBytes = 16'hFFFF;
		txStart = 1'b1;
		@(negedge mclk) txStart = 1'b0;
		run = 1'b1;
		repeat (3) @(negedge linkClock);
		chk("mid oe sending", 8'h03, {6'h00, lsD.oe, lsS.oe});
		@(negedge mclk) sysRst = 1'b1;
		repeat (2) @(negedge mclk);
		chk("mid oe in reset", 8'h00, {3'h0, lsD.oe, lsS.oe, ldo.oe, lso.oe, txBusy});
		@(negedge linkClock);
		@(negedge mclk) run = 1'b0;
		sysRst = 1'b0;
		repeat (2) @(negedge mclk);
		chk("mid oe released", 8'h00, {3'h0, lsD.oe, lsS.oe, ldo.oe, lso.oe, txBusy});
		$display("test mid reset done");
	endtask : test_mid_reset
	task report_and_stop;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#100000 n_fail++;
		report_and_stop();
	end
	initial
	begin
		repeat (4) @(negedge mclk);
		test_reset();
		test_receive();
		test_three_pin();
		test_five_pin();
		test_mid_reset();
		report_and_stop();
	end
endmodule : media_link_pin_port_bench
